//--- hw/slp_regs.svh
// constants of the sleep-mode controller: field positions, codes, timing counts
`ifndef SLP_REGS_SVH
`define SLP_REGS_SVH

// ******************************************
// mode codes of sleep_mode_select
// ******************************************
`define SLP_SEL_IDLE 3'h0
`define SLP_SEL_ADCNR 3'h1
`define SLP_SEL_PDOWN 3'h2
`define SLP_SEL_PSAVE 3'h3
`define SLP_SEL_STBY 3'h6
`define SLP_SEL_XSTBY 3'h7

// ******************************************
// mcu_ctrl_reg field positions
// ******************************************
`define SLP_MCR_BOFF_BIT 6
`define SLP_MCR_UNLOCK_BIT 5

// ******************************************
// timing
// ******************************************
`define SLP_CLK_MHZ 50
`define SLP_IRQ_HOLD_CYC 4
`define SLP_XTAL_WAKE_CYC 6
`define SLP_UNLOCK_WIN_CYC 4
`define SLP_BOFF_DELAY_CYC 3
`define SLP_BOFF_LIFE_CYC 3
`define SLP_BOD_WAKE_US 60
`define SLP_BOD_WAKE_CYC (`SLP_BOD_WAKE_US * `SLP_CLK_MHZ)

`endif

//--- hw/slp_pkg.sv
// types shared by the sleep-mode controller
package slp_pkg;

	// ******************************************
	// controller states, one-hot
	// ******************************************
	typedef enum logic [3:0] {
		SLP_ST_RUN = 4'h1,
		SLP_ST_SLEEP = 4'h2,
		SLP_ST_WAKE = 4'h4,
		SLP_ST_HOLD = 4'h8
	} slp_state_t;

	// ******************************************
	// decoded sleep mode
	// ******************************************
	typedef enum logic [2:0] {
		SLP_M_IDLE = 3'h0,
		SLP_M_ADCNR = 3'h1,
		SLP_M_PDOWN = 3'h2,
		SLP_M_PSAVE = 3'h3,
		SLP_M_STBY = 3'h6,
		SLP_M_XSTBY = 3'h7
	} slp_mode_t;

endpackage

//--- hw/slp_brownout_sleep_off_seq.sv
// timed write sequence of brownout_sleep_off in mcu_ctrl_reg
`timescale 1ns/1ns
`include "slp_regs.svh"
module slp_brownout_sleep_off_seq
	import slp_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// cpu write to mcu_ctrl_reg
	input wire logic mcr_wr_i,
	input wire logic [7:0] mcr_wdata_i,
	// state
	output logic brownout_sleep_off_active_o,
	output logic brownout_sleep_off_bit_o
);
	typedef struct packed {
		logic [2:0] win;
		logic [2:0] dly;
		logic [2:0] life;
		logic bit_set;
		logic active;
	} slp_brownout_sleep_off_t;

	slp_brownout_sleep_off_t q, d;

	always_comb begin
		d = q;
		if (q.win != 3'h0) begin
			d.win = q.win - 3'h1;
		end
		if (q.dly != 3'h0) begin
			d.dly = q.dly - 3'h1;
			if (q.dly == 3'h1) begin
				d.active = 1'b1;
				d.life = 3'(`SLP_BOFF_LIFE_CYC);
			end
		end
		if (q.life != 3'h0) begin
			d.life = q.life - 3'h1;
			if (q.life == 3'h1) begin
				d.active = 1'b0;
				d.bit_set = 1'b0;
			end
		end
		if (mcr_wr_i) begin
			if (mcr_wdata_i[`SLP_MCR_BOFF_BIT] && mcr_wdata_i[`SLP_MCR_UNLOCK_BIT]) begin
				d.win = 3'(`SLP_UNLOCK_WIN_CYC);
			end else if (mcr_wdata_i[`SLP_MCR_BOFF_BIT] && q.win != 3'h0) begin
				d.win = 3'h0;
				d.bit_set = 1'b1;
				d.dly = 3'(`SLP_BOFF_DELAY_CYC);
			end else if (!mcr_wdata_i[`SLP_MCR_BOFF_BIT]) begin
				d.bit_set = 1'b0;
				d.active = 1'b0;
				d.dly = 3'h0;
				d.life = 3'h0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign brownout_sleep_off_active_o = q.active;
	assign brownout_sleep_off_bit_o = q.bit_set;
endmodule

//--- hw/slp_wake_filter.sv
// per-mode wake-up source qualification
`timescale 1ns/1ns
module slp_wake_filter
	import slp_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// mode and configuration
	input wire slp_mode_t mode_i,
	input wire logic t2_async_i,
	input wire logic [1:0] t2_mask_i,
	input wire logic gie_i,
	// synchronised sources
	input wire logic [1:0] ext_irq_level_i,
	input wire logic [1:0] ext_irq_edge_i,
	input wire logic pin_change_i,
	input wire logic twi_match_i,
	input wire logic wdt_irq_i,
	input wire logic [1:0] t2_event_i,
	input wire logic spm_ready_i,
	input wire logic adc_done_i,
	input wire logic periph_irq_i,
	// qualified interrupt wake
	output logic irq_wake_o
);
	typedef struct packed {
		logic wake;
	} slp_wf_t;

	slp_wf_t q, d;
	logic async_src;
	logic t2_hit;

	always_comb begin
		d = q;
		// level only for deeper modes
		async_src = (|ext_irq_level_i) | pin_change_i | twi_match_i | wdt_irq_i;
		t2_hit = gie_i & (|(t2_event_i & t2_mask_i));
		unique case (mode_i)
			SLP_M_IDLE: begin
				d.wake = async_src | (|ext_irq_edge_i) | (|t2_event_i) | spm_ready_i
					| adc_done_i | periph_irq_i;
			end
			SLP_M_ADCNR: begin
				d.wake = async_src | adc_done_i | spm_ready_i
					| ((|t2_event_i) & t2_async_i);
			end
			SLP_M_PSAVE, SLP_M_XSTBY: begin
				d.wake = async_src | t2_hit;
			end
			default: begin
				d.wake = async_src;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign irq_wake_o = q.wake;
endmodule

//--- hw/slp_ctrl.sv
// sleep-mode controller: entry, clock gating, wake-up timing, brown-out control
//
// Behaviour
// - sleep only when sleep_allow is one and sleep instruction runs; mode from select
// - select 000 Idle: cpu and flash clocks stop, others run; sync clock to timer stays off here
// - select 001 noise reduction: io, cpu, flash stop; converter, async, main run
// - noise reduction wakes only on listed converter, spm ready, timer, two-wire, watchdog, level, pin events
// - select 010 Power-down: oscillator off, all generated clocks halted
// - Power-down wakes only on resets, watchdog, two-wire match, level, pin change
// - Power-down wake delayed by fuse-selected start-up period
// - select 011 Power-save: timer_two runs, masked events wake with global enable
// - Power-save stops unused timer oscillator or main source; sync clock only to timer
// - select 110 with crystal Standby: oscillator kept, wake in six cycles
// - interrupt wake holds cpu four cycles beyond start-up, then resumes
// - sleep leaves register file and sram untouched
// - reset during sleep wakes; execution restarts at reset vector
// - deeper modes accept only level external interrupts
// - Idle accepts external and internal peripheral interrupts
// - converter enabled: entering Idle or noise reduction starts a conversion
// - software brown-out off only in deep modes and when fuses enable detector
// - detector off right after sleep entry, back on at wake-up
// - detector was off: wake time stretched to about 60 us
// - brownout_sleep_off at bit 6, one disables, resets to zero
// - unlock write, then within four cycles set; active after three, clears after three
// - select 111 with crystal Extended Standby: as Power-save, oscillator kept, six cycles; sync clock to timer stays off here
`timescale 1ns/1ns
`include "slp_regs.svh"
module slp_ctrl
	import slp_pkg::*;
#(
	parameter int unsigned BOD_WAKE_CYC = `SLP_BOD_WAKE_CYC
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// cpu side
	input wire logic sleep_instr_i,
	input wire logic sleep_allow_i,
	input wire logic [2:0] sleep_mode_select_i,
	input wire logic mcr_wr_i,
	input wire logic [7:0] mcr_wdata_i,
	input wire logic gie_i,
	input wire logic [1:0] timer2_irq_mask_i,
	// configuration
	input wire logic [15:0] startup_cyc_i,
	input wire logic xtal_sel_i,
	input wire logic bod_fuse_en_i,
	input wire logic adc_enabled_i,
	input wire logic t2_enabled_i,
	input wire logic t2_async_i,
	// wake sources from pins and async logic
	input wire logic [1:0] ext_irq_level_i,
	input wire logic [1:0] ext_irq_edge_i,
	input wire logic pin_change_i,
	input wire logic twi_match_i,
	input wire logic wdt_irq_i,
	input wire logic [1:0] t2_event_i,
	// wake sources from synchronous logic
	input wire logic spm_ready_i,
	input wire logic adc_done_i,
	input wire logic periph_irq_i,
	input wire logic any_reset_i,
	// clock domain enables
	output logic cpu_clock_en_o,
	output logic flash_clock_en_o,
	output logic io_clock_en_o,
	output logic converter_clock_en_o,
	output logic async_timer_clock_en_o,
	output logic t2_sync_clock_en_o,
	output logic main_osc_en_o,
	output logic timer_osc_en_o,
	// status and control
	output logic bod_en_o,
	output logic adc_start_o,
	output logic sleeping_o,
	output logic irq_resume_o,
	output logic reset_vector_o,
	output logic brownout_sleep_off_o
);
	// ******************************************
	// state
	// ******************************************
	typedef struct packed {
		slp_state_t st;
		slp_mode_t mode;
		logic [15:0] cnt;
		logic bod_off;
		logic [1:0][3:0] sync;
		// first and second stage of {timer events, watchdog, edge irqs}
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic cpu_en;
		logic flash_en;
		logic io_en;
		logic adc_en;
		logic asy_en;
		logic t2s_en;
		logic main_en;
		logic tosc_en;
		logic bod_en;
		logic adc_start;
		logic sleeping;
		logic irq_resume;
		logic rst_vec;
		logic brownout_sleep_off;
	} slp_ctrl_t;

	slp_ctrl_t q, d;
	logic irq_wake;
	logic brownout_sleep_off_active;
	logic brownout_sleep_off_bit;
	slp_mode_t sel_mode;

	// ******************************************
	// helpers
	// ******************************************
	// reserved selections fall back to Idle; standby without crystal acts as Power-down
	function automatic slp_mode_t decode_mode(input logic [2:0] sel, input logic xtal);
		unique case (sel)
			`SLP_SEL_IDLE: decode_mode = SLP_M_IDLE;
			`SLP_SEL_ADCNR: decode_mode = SLP_M_ADCNR;
			`SLP_SEL_PDOWN: decode_mode = SLP_M_PDOWN;
			`SLP_SEL_PSAVE: decode_mode = SLP_M_PSAVE;
			`SLP_SEL_STBY: decode_mode = xtal ? SLP_M_STBY : SLP_M_PDOWN;
			`SLP_SEL_XSTBY: decode_mode = xtal ? SLP_M_XSTBY : SLP_M_PSAVE;
			default: decode_mode = SLP_M_IDLE;
		endcase
	endfunction

	function automatic logic deep_mode(input slp_mode_t m);
		deep_mode = (m != SLP_M_IDLE) && (m != SLP_M_ADCNR);
	endfunction

	assign sel_mode = decode_mode(sleep_mode_select_i, xtal_sel_i);

	// ******************************************
	// submodules
	// ******************************************
	slp_brownout_sleep_off_seq u_brownout_sleep_off (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.mcr_wr_i(mcr_wr_i),
		.mcr_wdata_i(mcr_wdata_i),
		.brownout_sleep_off_active_o(brownout_sleep_off_active),
		.brownout_sleep_off_bit_o(brownout_sleep_off_bit)
	);

	// pin sources enter after the second synchroniser stage only
	slp_wake_filter u_wake (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.mode_i(q.mode),
		.t2_async_i(t2_async_i),
		.t2_mask_i(timer2_irq_mask_i),
		.gie_i(gie_i),
		.ext_irq_level_i(q.sync[1][1:0]),
		.ext_irq_edge_i(q.sync2[1:0]),
		.pin_change_i(q.sync[1][2]),
		.twi_match_i(q.sync[1][3]),
		.wdt_irq_i(q.sync2[2]),
		.t2_event_i(q.sync2[4:3]),
		.spm_ready_i(spm_ready_i),
		.adc_done_i(adc_done_i),
		.periph_irq_i(periph_irq_i),
		.irq_wake_o(irq_wake)
	);

	// ******************************************
	// next state
	// ******************************************
	always_comb begin
		d = q;
		// two-stage synchronisers for outside sources
		d.sync[0] = {twi_match_i, pin_change_i, ext_irq_level_i};
		d.sync[1] = q.sync[0];
		d.sync1 = {t2_event_i, wdt_irq_i, ext_irq_edge_i};
		d.sync2 = q.sync1;
		d.adc_start = 1'b0;
		d.irq_resume = 1'b0;
		d.brownout_sleep_off = brownout_sleep_off_bit;
		if (q.cnt != 16'h0) begin
			d.cnt = q.cnt - 16'h1;
		end
		unique case (q.st)
			SLP_ST_RUN: begin
				// register file and sram are not touched by any path here
				if (sleep_instr_i && sleep_allow_i) begin
					d.st = SLP_ST_SLEEP;
					d.mode = sel_mode;
					d.sleeping = 1'b1;
					d.cpu_en = 1'b0;
					d.flash_en = 1'b0;
					d.io_en = (sel_mode == SLP_M_IDLE);
					d.adc_en = (sel_mode == SLP_M_IDLE) || (sel_mode == SLP_M_ADCNR);
					d.asy_en = !deep_mode(sel_mode)
						|| ((sel_mode == SLP_M_PSAVE || sel_mode == SLP_M_XSTBY)
						&& t2_enabled_i && t2_async_i);
					// oscillator kept in standby modes; Power-down stops it
					d.main_en = !deep_mode(sel_mode) || sel_mode == SLP_M_STBY
						|| sel_mode == SLP_M_XSTBY
						|| (sel_mode == SLP_M_PSAVE && t2_enabled_i && !t2_async_i);
					d.t2s_en = sel_mode == SLP_M_PSAVE && t2_enabled_i && !t2_async_i;
					d.tosc_en = t2_enabled_i && t2_async_i && sel_mode != SLP_M_PDOWN
						&& sel_mode != SLP_M_STBY;
					d.adc_start = adc_enabled_i && !deep_mode(sel_mode);
					d.bod_off = brownout_sleep_off_active && bod_fuse_en_i && deep_mode(sel_mode);
					d.bod_en = !(brownout_sleep_off_active && bod_fuse_en_i && deep_mode(sel_mode));
				end
				// without sleep_allow the instruction simply retires
			end
			SLP_ST_SLEEP: begin
				if (irq_wake) begin
					d.st = SLP_ST_WAKE;
					d.bod_en = 1'b1;
					d.main_en = 1'b1;
					d.tosc_en = t2_enabled_i && t2_async_i;
					if (q.mode == SLP_M_STBY || q.mode == SLP_M_XSTBY) begin
						d.cnt = 16'(`SLP_XTAL_WAKE_CYC);
					end else if (deep_mode(q.mode)) begin
						d.cnt = startup_cyc_i;
					end else begin
						d.cnt = 16'h1;
					end
					if (q.bod_off && d.cnt < 16'(BOD_WAKE_CYC)) begin
						d.cnt = 16'(BOD_WAKE_CYC);
					end
				end
			end
			SLP_ST_WAKE: begin
				if (q.cnt <= 16'h1) begin
					d.st = SLP_ST_HOLD;
					d.cnt = 16'(`SLP_IRQ_HOLD_CYC);
					d.io_en = 1'b1;
					d.adc_en = 1'b1;
					d.asy_en = 1'b1;
					d.t2s_en = 1'b0;
				end
			end
			SLP_ST_HOLD: begin
				if (q.cnt <= 16'h1) begin
					d.st = SLP_ST_RUN;
					d.cpu_en = 1'b1;
					d.flash_en = 1'b1;
					d.sleeping = 1'b0;
					d.bod_off = 1'b0;
					d.irq_resume = 1'b1;
				end
			end
		endcase
		// a reset outside SLP_ST_RUN always wins and restarts at the reset vector
		d.rst_vec = 1'b0;
		if (any_reset_i && q.st != SLP_ST_RUN) begin
			d.st = SLP_ST_RUN;
			d.rst_vec = 1'b1;
			d.cpu_en = 1'b1;
			d.flash_en = 1'b1;
			d.io_en = 1'b1;
			d.adc_en = 1'b1;
			d.asy_en = 1'b1;
			d.t2s_en = 1'b0;
			d.main_en = 1'b1;
			d.tosc_en = t2_enabled_i && t2_async_i;
			d.bod_en = 1'b1;
			d.bod_off = 1'b0;
			d.sleeping = 1'b0;
			d.irq_resume = 1'b0;
			d.cnt = 16'h0;
		end
	end

	// ******************************************
	// registers
	// ******************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			q <= '0;
			q.st <= SLP_ST_RUN;
			q.mode <= SLP_M_IDLE;
			q.cpu_en <= 1'b1;
			q.flash_en <= 1'b1;
			q.io_en <= 1'b1;
			q.adc_en <= 1'b1;
			q.asy_en <= 1'b1;
			q.main_en <= 1'b1;
			q.bod_en <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ******************************************
	// outputs, all from flip-flops
	// ******************************************
	assign cpu_clock_en_o = q.cpu_en;
	assign flash_clock_en_o = q.flash_en;
	assign io_clock_en_o = q.io_en;
	assign converter_clock_en_o = q.adc_en;
	assign async_timer_clock_en_o = q.asy_en;
	assign t2_sync_clock_en_o = q.t2s_en;
	assign main_osc_en_o = q.main_en;
	assign timer_osc_en_o = q.tosc_en;
	assign bod_en_o = q.bod_en;
	assign adc_start_o = q.adc_start;
	assign sleeping_o = q.sleeping;
	assign irq_resume_o = q.irq_resume;
	assign reset_vector_o = q.rst_vec;
	assign brownout_sleep_off_o = q.brownout_sleep_off;
endmodule

//--- bench/slp_ctrl_assertions.sv
// port-level checker of the sleep-mode controller
`timescale 1ns/1ns
module slp_ctrl_assertions (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// cpu side
	input wire logic sleep_instr_i,
	input wire logic sleep_allow_i,
	input wire logic [2:0] sleep_mode_select_i,
	input wire logic mcr_wr_i,
	input wire logic [7:0] mcr_wdata_i,
	input wire logic adc_enabled_i,
	input wire logic any_reset_i,
	// observed outputs
	input wire logic cpu_clock_en_o,
	input wire logic flash_clock_en_o,
	input wire logic io_clock_en_o,
	input wire logic converter_clock_en_o,
	input wire logic main_osc_en_o,
	input wire logic bod_en_o,
	input wire logic adc_start_o,
	input wire logic sleeping_o,
	input wire logic irq_resume_o,
	input wire logic reset_vector_o,
	input wire logic brownout_sleep_off_o
);
	// ******************************************
	// properties
	// ******************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	a_sleep_entry: assert property (
		(sleep_instr_i && sleep_allow_i && cpu_clock_en_o && !sleeping_o)
		|=> (sleeping_o && !cpu_clock_en_o && !flash_clock_en_o)) else $error("sleep not entered");
	a_no_allow: assert property (
		(sleep_instr_i && !sleep_allow_i && cpu_clock_en_o && !sleeping_o) |=> !sleeping_o)
		else $error("sleep entered without allow");
	a_idle_clocks: assert property (
		$rose(sleeping_o) && $past(sleep_mode_select_i) == 3'h0
		|-> io_clock_en_o && converter_clock_en_o && main_osc_en_o && bod_en_o)
		else $error("idle clocks wrong");
	a_adcnr_clocks: assert property (
		$rose(sleeping_o) && $past(sleep_mode_select_i) == 3'h1
		|-> !io_clock_en_o && converter_clock_en_o && main_osc_en_o)
		else $error("noise reduction clocks wrong");
	a_pdown_clocks: assert property (
		$rose(sleeping_o) && $past(sleep_mode_select_i) == 3'h2
		|-> !(io_clock_en_o || converter_clock_en_o || main_osc_en_o))
		else $error("power-down clocks running");
	a_adc_start: assert property (
		(sleep_instr_i && sleep_allow_i && cpu_clock_en_o && !sleeping_o && adc_enabled_i
		&& sleep_mode_select_i[2:1] == 2'h0) |-> ##[0:1] adc_start_o)
		else $error("no conversion start");
	a_resume_hold: assert property (
		irq_resume_o |-> cpu_clock_en_o && !$past(cpu_clock_en_o, 4) && $past(io_clock_en_o, 4))
		else $error("resume hold wrong");
	a_reset_wake: assert property (
		(any_reset_i && !cpu_clock_en_o) |=> (reset_vector_o && cpu_clock_en_o && io_clock_en_o))
		else $error("reset did not wake");
	a_brownout_sleep_off_clear: assert property (
		(mcr_wr_i && !mcr_wdata_i[6]) |=> ##1 !brownout_sleep_off_o) else $error("bit not cleared");
	a_brownout_sleep_off_life: assert property (
		$rose(brownout_sleep_off_o) |-> ##[1:8] !brownout_sleep_off_o) else $error("bit stuck");
	a_bod_sleep_only: assert property (
		!bod_en_o |-> !cpu_clock_en_o) else $error("detector off while running");
endmodule
bind slp_ctrl slp_ctrl_assertions i_chk (.*);

//--- bench/slp_irq_model.sv
// interrupt source model: holds its request until the cpu takes it
`timescale 1ns/1ns
module slp_irq_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// trigger and acknowledge
	input wire logic fire_i,
	input wire logic ack_i,
	// request level
	output logic irq_o
);
	// a level, since a pulse could be lost while the clocks are stopped
	always_ff @(posedge clock_i) begin
		if (srst_i || ack_i) begin
			irq_o <= 1'b0;
		end else if (fire_i) begin
			irq_o <= 1'b1;
		end
	end
endmodule

//--- bench/slp_ctrl_tb_top.sv
// self-checking bench of the sleep-mode controller
`timescale 1ns/1ns
module slp_ctrl_tb_top;
	logic clock_i, srst_i, sleep_instr_i, sleep_allow_i, mcr_wr_i, xtal_sel_i;
	logic adc_enabled_i, any_reset_i, g, wdt_irq;
	logic cpu_clock_en_o, bod_en_o, sleeping_o, irq_resume_o, reset_vector_o;
	logic brownout_sleep_off_o;
	logic [2:0] sleep_mode_select_i;
	logic [7:0] mcr_wdata_i;
	logic [15:0] startup_cyc_i;
	logic [6:0] s;
	int err_total, compares, cyc, n;
	// {mode, source, global enable, wakes}
	logic [7:0] rows [13] = '{8'h03, 8'h26, 8'h2B, 8'h3B, 8'h42, 8'h46, 8'h57, 8'h4B,
		8'h73, 8'h70, 8'h52, 8'hCF, 8'hF3};

	slp_ctrl #(.BOD_WAKE_CYC(40)) i_dut (.*,
		.gie_i(g), .timer2_irq_mask_i({2{g}}), .bod_fuse_en_i(1'b1), .t2_enabled_i(1'b1),
		.t2_async_i(1'b1), .ext_irq_level_i({1'b0, s[2]}), .ext_irq_edge_i({1'b0, s[1]}),
		.pin_change_i(s[3]), .twi_match_i(s[3]), .wdt_irq_i(wdt_irq), .t2_event_i({1'b0, s[4]}),
		.spm_ready_i(1'b0), .adc_done_i(s[6]), .periph_irq_i(s[0]), .flash_clock_en_o(),
		.io_clock_en_o(), .converter_clock_en_o(), .async_timer_clock_en_o(),
		.t2_sync_clock_en_o(), .main_osc_en_o(), .timer_osc_en_o(), .adc_start_o());
	slp_irq_model i_irq (.clock_i(clock_i), .srst_i(srst_i), .fire_i(s[5]),
		.ack_i(irq_resume_o | reset_vector_o), .irq_o(wdt_irq));

	// ******************************************
	// tasks
	// ******************************************
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task go(input logic [2:0] m);
		sleep_mode_select_i = m;
		sleep_instr_i = 1'b1;
		@(negedge clock_i);
		sleep_instr_i = 1'b0;
		@(negedge clock_i);
	endtask
	// bounded wait: a wake source that is refused must not hang the run
	task wake;
		n = 0;
		while (irq_resume_o !== 1'b1 && n < 80) begin
			@(negedge clock_i);
			n++;
		end
	endtask

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end

	// ******************************************
	// sequence
	// ******************************************
	initial begin
		srst_i = 1'b1;
		sleep_instr_i = 1'b0;
		sleep_allow_i = 1'b1;
		sleep_mode_select_i = 3'h0;
		mcr_wr_i = 1'b0;
		mcr_wdata_i = 8'h00;
		g = 1'b1;
		startup_cyc_i = 16'h0014;
		xtal_sel_i = 1'b1;
		adc_enabled_i = 1'b1;
		any_reset_i = 1'b0;
		s = 7'h00;
		repeat (8) @(negedge clock_i);
		srst_i = 1'b0;
		chk(brownout_sleep_off_o, 1'b0);
		chk(bod_en_o, 1'b1);
		sleep_allow_i = 1'b0;
		go(3'h0);
		chk(sleeping_o, 1'b0);
		sleep_allow_i = 1'b1;
		foreach (rows[i]) begin
			g = rows[i][1];
			go(rows[i][7:5]);
			chk(sleeping_o, 1'b1);
			s[rows[i][4:2]] = 1'b1;
			wake();
			s = 7'h00;
			chk(irq_resume_o, rows[i][0]);
			if (rows[i][7:5] inside {3'h2, 3'h3} && rows[i][0]) chk(n >= 24, 1'b1);
			if (rows[i][7:5] == 3'h6 && rows[i][0]) chk(n <= 18, 1'b1);
			if (!rows[i][0]) begin
				any_reset_i = 1'b1;
				@(negedge clock_i);
				any_reset_i = 1'b0;
				chk(reset_vector_o, 1'b1);
			end
			// let the synchronisers drain so no stale source wakes the next row
			repeat (3) @(negedge clock_i);
		end
		xtal_sel_i = 1'b0;
		adc_enabled_i = 1'b0;
		mcr_wr_i = 1'b1;
		mcr_wdata_i = 8'h60;
		@(negedge clock_i);
		mcr_wdata_i = 8'h40;
		@(negedge clock_i);
		mcr_wr_i = 1'b0;
		@(negedge clock_i);
		chk(brownout_sleep_off_o, 1'b1);
		repeat (3) @(negedge clock_i);
		go(3'h2);
		chk(bod_en_o, 1'b0);
		s[5] = 1'b1;
		wake();
		s = 7'h00;
		chk(n >= 44, 1'b1);
		chk(bod_en_o, 1'b1);
		mcr_wr_i = 1'b1;
		mcr_wdata_i = 8'h60;
		@(negedge clock_i);
		mcr_wdata_i = 8'h40;
		@(negedge clock_i);
		mcr_wdata_i = 8'h00;
		@(negedge clock_i);
		mcr_wr_i = 1'b0;
		@(negedge clock_i);
		chk(brownout_sleep_off_o, 1'b0);
		summarize();
	end
endmodule
